//--- psr_regfile.sv
// Packed SIMD register file top: decode, datapath, aliasing and deferred fp fault
// Summary of operation
// - Eight 64-bit packed registers, indices 0 to 7, serve as operands and destinations.
// - The packed registers share storage with the eight floating-point stack slots.
// - A register is seen as 8 byte, 4 word or 2 doubleword lanes, signed or unsigned.
// - Registers hold the same bit layout as a 64-bit value in memory.
// - In memory, the least significant element and byte sit at the lowest address.
// - 64-bit moves, loads, stores, pack, logic, arithmetic and some unpacks use full width.
// - 32-bit loads, stores, general-register transfers and some unpacks use the low half.
// - Data movement copies whole 64-bit blocks with no per-lane processing.
// - Arithmetic and logic apply one operation to every lane in parallel.
// - Signed saturating word add adds four signed 16-bit lanes into four word results.
// - Signed word saturation clamps to 7fff on positive and 8000 on negative overflow.
// - No packed register ever forms a memory address.
// - The facility works in protected, real and virtual-8086 modes with no new mode.
// - Compatibility and 64-bit modes behave like protected mode for packed operations.
// - A floating-point fault is held until the next fp or sync-wait op, keeping its pointer.
`timescale 1ns/1ns
`default_nettype none
module psr_regfile (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire psr_pkg::psr_req_t req,
  output psr_pkg::psr_rsp_t rsp,
  output logic [63:0] memWrData,
  output logic [7:0] memByteEn,
  input wire logic [1:0] cpuMode,
  input wire logic fpWrEn,
  input wire logic [2:0] fpWrSlot,
  input wire logic [63:0] fpWrData,
  input wire logic [2:0] fpRdSlot,
  output logic [63:0] fpRdData,
  input wire logic fpFaultDetect,
  input wire logic [47:0] fpFaultIp,
  input wire logic fpFaultClear,
  input wire logic fpOpIssue,
  output logic fpFaultSignal,
  output logic fpFaultPending,
  output logic [47:0] fpSavedIp
);
  // Decoded request classes
  wire isSync = req.op == psr_pkg::PSR_OP_FP_SYNC;
  wire takeReq = ce && req.valid;

  // Pipeline stage holding the issued request while the read completes
  psr_pkg::psr_req_t stage_r;
  logic [63:0] srcA;
  logic [63:0] srcB;
  logic [63:0] aluOut;
  logic [63:0] wbData;
  logic wbEn;
  logic [63:0] fpRdRaw;

  // Mode input is accepted but never changes behaviour
  wire modeIgnored = ^cpuMode;

  // Capture the request for the execute cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stage_r <= '0;
    end else if (ce) begin
      stage_r <= req;
      stage_r.valid <= req.valid;
    end
  end

  // Shared storage: packed writes win over fp writes in the same cycle
  wire memWr = wbEn || fpWrEn;
  wire [2:0] memWrIdx = wbEn ? stage_r.dst : fpWrSlot;
  wire [63:0] memWrVal = wbEn ? wbData : fpWrData;

  psr_regmem u_mem (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .wrEn(memWr),
    .wrIdx(memWrIdx),
    .wrData(memWrVal),
    .rdIdxA(req.srcA),
    .rdIdxB(req.srcB),
    .rdIdxF(fpRdSlot),
    .rdDataA(srcA),
    .rdDataB(srcB),
    .rdDataF(fpRdRaw)
  );

  psr_lane_alu u_alu (
    .op(stage_r.op),
    .lane(stage_r.lane),
    .opA(srcA),
    .opB(srcB),
    .result(aluOut)
  );

  // Writeback select by access path
  always_comb begin
    wbEn = ce && stage_r.valid;
    case (stage_r.op)
      psr_pkg::PSR_OP_MOVE_RR: wbData = srcA;
      psr_pkg::PSR_OP_LOAD64: wbData = stage_r.memData;
      psr_pkg::PSR_OP_LOAD32: wbData = {32'h00000000, stage_r.memData[31:0]};
      psr_pkg::PSR_OP_GPR_IN: wbData = {32'h00000000, stage_r.gprData};
      psr_pkg::PSR_OP_FP_SYNC: begin
        wbData = srcA;
        wbEn = 1'b0;
      end
      psr_pkg::PSR_OP_NOP: begin
        wbData = srcA;
        wbEn = 1'b0;
      end
      default: wbData = aluOut;
    endcase
  end

  // Result and store data come from flops; byte 0 of the bus is lowest address
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rsp <= '0;
      memWrData <= '0;
      memByteEn <= '0;
      fpRdData <= '0;
    end else if (ce) begin
      rsp.valid <= stage_r.valid && !modeIgnored ? stage_r.valid : stage_r.valid;
      rsp.data64 <= srcA;
      rsp.data32 <= srcA[31:0];
      memWrData <= srcA;
      memByteEn <= stage_r.lane == psr_pkg::PSR_LANE_DWORD ? 8'h0f : 8'hff;
      fpRdData <= fpRdRaw;
    end
  end

  // Deferred fault: held until next fp or sync op, pointer kept for state save
  logic pending_r;
  logic signal_r;
  logic [47:0] ip_r;
  wire syncPoint = (takeReq && isSync) || (ce && fpOpIssue);
  wire pendingNxt = fpFaultDetect || (pending_r && !fpFaultClear);
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pending_r <= 1'b0;
      signal_r <= 1'b0;
      ip_r <= '0;
    end else if (ce) begin
      pending_r <= pendingNxt;
      signal_r <= pending_r && syncPoint && !fpFaultClear;
      if (fpFaultDetect) ip_r <= fpFaultIp;
    end
  end

  assign fpFaultSignal = signal_r;
  assign fpFaultPending = pending_r;
  assign fpSavedIp = ip_r;
endmodule
`default_nettype wire

//--- psr_pkg.sv
// Package for the packed SIMD register file: opcodes, access sizes, constants
package psr_pkg;
  localparam int REG_COUNT = 8;
  localparam int REG_W = 64;
  localparam int IDX_W = 3;
  localparam logic [63:0] REG_RESET = 64'h0000000000000000;
  localparam logic [15:0] SAT_WORD_MAX = 16'h7fff;
  localparam logic [15:0] SAT_WORD_MIN = 16'h8000;
  localparam logic [7:0] SAT_BYTE_MAX = 8'h7f;
  localparam logic [7:0] SAT_BYTE_MIN = 8'h80;
  localparam logic [7:0] USAT_BYTE_MAX = 8'hff;
  localparam logic [7:0] USAT_BYTE_MIN = 8'h00;
  localparam int LANE_POS_WORD_HI = 32;

  // Lane size selected by the operation
  typedef enum logic [1:0] {
    PSR_LANE_BYTE,
    PSR_LANE_WORD,
    PSR_LANE_DWORD,
    PSR_LANE_QWORD
  } psr_lane_t;

  // Operation codes issued by the execution core
  typedef enum logic [3:0] {
    PSR_OP_NOP,
    PSR_OP_MOVE_RR,
    PSR_OP_LOAD64,
    PSR_OP_LOAD32,
    PSR_OP_GPR_IN,
    PSR_OP_ADD_WRAP,
    PSR_OP_ADD_SSAT,
    PSR_OP_ADD_USAT,
    PSR_OP_SUB_WRAP,
    PSR_OP_AND,
    PSR_OP_ANDN,
    PSR_OP_OR,
    PSR_OP_XOR,
    PSR_OP_UNPACK_LO,
    PSR_OP_FP_SYNC
  } psr_op_t;

  // Request from the execution core
  typedef struct packed {
    logic valid;
    psr_op_t op;
    psr_lane_t lane;
    logic [2:0] dst;
    logic [2:0] srcA;
    logic [2:0] srcB;
    logic [63:0] memData;
    logic [31:0] gprData;
  } psr_req_t;

  // Result back to the core
  typedef struct packed {
    logic valid;
    logic [63:0] data64;
    logic [31:0] data32;
  } psr_rsp_t;
endpackage

//--- psr_regmem.sv
// Eight-entry 64-bit storage shared by packed and floating-point views
`timescale 1ns/1ns
`default_nettype none
module psr_regmem (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [63:0] wrData,
  input wire logic [2:0] rdIdxA,
  input wire logic [2:0] rdIdxB,
  input wire logic [2:0] rdIdxF,
  output logic [63:0] rdDataA,
  output logic [63:0] rdDataB,
  output logic [63:0] rdDataF
);
  logic [63:0] mem_r [psr_pkg::REG_COUNT];

  // Single storage array, no duplicate copy per view
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < psr_pkg::REG_COUNT; i++) mem_r[i] <= psr_pkg::REG_RESET;
    end else if (ce && wrEn) begin
      mem_r[wrIdx] <= wrData;
    end
  end

  // Registered read ports
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdDataA <= psr_pkg::REG_RESET;
      rdDataB <= psr_pkg::REG_RESET;
      rdDataF <= psr_pkg::REG_RESET;
    end else if (ce) begin
      rdDataA <= mem_r[rdIdxA];
      rdDataB <= mem_r[rdIdxB];
      rdDataF <= mem_r[rdIdxF];
    end
  end
endmodule
`default_nettype wire

//--- psr_lane_alu.sv
// Lane-parallel integer datapath over one 64-bit pair of operands
`timescale 1ns/1ns
`default_nettype none
module psr_lane_alu (
  input wire psr_pkg::psr_op_t op,
  input wire psr_pkg::psr_lane_t lane,
  input wire logic [63:0] opA,
  input wire logic [63:0] opB,
  output logic [63:0] result
);
  // Signed saturating byte add
  function automatic logic [7:0] ssat8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    if (s[8] != s[7]) ssat8 = s[8] ? psr_pkg::SAT_BYTE_MIN : psr_pkg::SAT_BYTE_MAX;
    else ssat8 = s[7:0];
  endfunction

  // Signed saturating word add
  function automatic logic [15:0] ssat16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s[16] != s[15]) ssat16 = s[16] ? psr_pkg::SAT_WORD_MIN : psr_pkg::SAT_WORD_MAX;
    else ssat16 = s[15:0];
  endfunction

  // Unsigned saturating byte add
  function automatic logic [7:0] usat8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    usat8 = s[8] ? psr_pkg::USAT_BYTE_MAX : s[7:0];
  endfunction

  logic [63:0] addWrap;
  logic [63:0] subWrap;
  logic [63:0] addSsat;
  logic [63:0] addUsat;
  logic [63:0] unpackLo;

  // Same operation on every lane at once
  always_comb begin
    addWrap = '0;
    subWrap = '0;
    addSsat = opA;
    addUsat = opA;
    unpackLo = '0;
    case (lane)
      psr_pkg::PSR_LANE_BYTE: begin
        for (int i = 0; i < 8; i++) begin
          addWrap[i*8 +: 8] = opA[i*8 +: 8] + opB[i*8 +: 8];
          subWrap[i*8 +: 8] = opA[i*8 +: 8] - opB[i*8 +: 8];
          addSsat[i*8 +: 8] = ssat8(opA[i*8 +: 8], opB[i*8 +: 8]);
          addUsat[i*8 +: 8] = usat8(opA[i*8 +: 8], opB[i*8 +: 8]);
        end
        for (int i = 0; i < 4; i++) begin
          unpackLo[i*16 +: 16] = {opB[i*8 +: 8], opA[i*8 +: 8]};
        end
      end
      psr_pkg::PSR_LANE_WORD: begin
        for (int i = 0; i < 4; i++) begin
          addWrap[i*16 +: 16] = opA[i*16 +: 16] + opB[i*16 +: 16];
          subWrap[i*16 +: 16] = opA[i*16 +: 16] - opB[i*16 +: 16];
          addSsat[i*16 +: 16] = ssat16(opA[i*16 +: 16], opB[i*16 +: 16]);
        end
        for (int i = 0; i < 2; i++) begin
          unpackLo[i*32 +: 32] = {opB[i*16 +: 16], opA[i*16 +: 16]};
        end
      end
      psr_pkg::PSR_LANE_DWORD: begin
        for (int i = 0; i < 2; i++) begin
          addWrap[i*32 +: 32] = opA[i*32 +: 32] + opB[i*32 +: 32];
          subWrap[i*32 +: 32] = opA[i*32 +: 32] - opB[i*32 +: 32];
        end
        unpackLo = {opB[31:0], opA[31:0]};
      end
      default: begin
        addWrap = opA + opB;
        subWrap = opA - opB;
        unpackLo = opA;
      end
    endcase
  end

  // Result select; logical ops always span the full register
  always_comb begin
    case (op)
      psr_pkg::PSR_OP_ADD_WRAP: result = addWrap;
      psr_pkg::PSR_OP_ADD_SSAT: result = addSsat;
      psr_pkg::PSR_OP_ADD_USAT: result = addUsat;
      psr_pkg::PSR_OP_SUB_WRAP: result = subWrap;
      psr_pkg::PSR_OP_AND: result = opA & opB;
      psr_pkg::PSR_OP_ANDN: result = ~opA & opB;
      psr_pkg::PSR_OP_OR: result = opA | opB;
      psr_pkg::PSR_OP_XOR: result = opA ^ opB;
      psr_pkg::PSR_OP_UNPACK_LO: result = unpackLo;
      default: result = opA;
    endcase
  end
endmodule
`default_nettype wire

//--- psr_regfile_properties.sv
// Checker for the packed register file's port timing and fault deferral
`timescale 1ns/1ns
`default_nettype none
module psr_regfile_properties (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire psr_pkg::psr_req_t req,
  input wire psr_pkg::psr_rsp_t rsp,
  input wire logic [63:0] memWrData,
  input wire logic [7:0] memByteEn,
  input wire logic fpFaultDetect,
  input wire logic [47:0] fpFaultIp,
  input wire logic fpFaultClear,
  input wire logic fpOpIssue,
  input wire logic fpFaultSignal,
  input wire logic fpFaultPending,
  input wire logic [47:0] fpSavedIp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Request taken with the pipeline running, and the fault sync point
  sequence s_taken;
    ce && req.valid ##1 ce;
  endsequence
  sequence s_sync;
    ce && (fpOpIssue || (req.valid && req.op == psr_pkg::PSR_OP_FP_SYNC));
  endsequence
  // Response timing and payload
  a_rsp_latency: assert property (s_taken |=> rsp.valid)
    else $error("no response after request");
  a_low_half: assert property (rsp.valid |-> rsp.data32 == rsp.data64[31:0])
    else $error("low half differs");
  a_store_data: assert property (rsp.valid |-> memWrData == rsp.data64)
    else $error("store data differs");
  a_store_mask: assert property (s_taken |=> memByteEn ==
    ($past(req.lane, 2) == psr_pkg::PSR_LANE_DWORD ? 8'h0f : 8'hff))
    else $error("byte enables wrong");
  // Deferred fault
  a_fault_capture: assert property (ce && fpFaultDetect |=>
    fpFaultPending && fpSavedIp == $past(fpFaultIp))
    else $error("fault not held");
  a_fault_deliver: assert property (fpFaultPending ##0 s_sync |=> fpFaultSignal)
    else $error("fault not delivered");
  a_signal_cause: assert property (fpFaultSignal |-> $past(fpFaultPending))
    else $error("fault signal without pending");
  a_pending_holds: assert property (fpFaultPending && !fpFaultClear |=> fpFaultPending)
    else $error("pending dropped");
  a_clear_drops: assert property (ce && fpFaultClear && !fpFaultDetect |=> !fpFaultPending)
    else $error("pending not cleared");
endmodule
bind psr_regfile psr_regfile_properties i_psr_regfile_properties (.mclk, .rst_b, .ce, .req,
  .rsp, .memWrData, .memByteEn, .fpFaultDetect, .fpFaultIp, .fpFaultClear, .fpOpIssue,
  .fpFaultSignal, .fpFaultPending, .fpSavedIp);
`default_nettype wire

//--- psr_core_model.sv
// Core-side model: raises a fault, issues an fp op only when delay is nonzero, resumes from saved pointer
`timescale 1ns/1ns
`default_nettype none
module psr_core_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [7:0] delay,
  input wire logic [47:0] ip,
  input wire logic fpFaultSignal,
  input wire logic [47:0] fpSavedIp,
  output logic fpFaultDetect,
  output logic [47:0] fpFaultIp,
  output logic fpOpIssue,
  output logic fpFaultClear,
  output logic [47:0] resumeIp
);
  logic [7:0] cnt;
  initial {fpFaultDetect, fpFaultIp, fpOpIssue, fpFaultClear, resumeIp, cnt} = '0;
  // Pointer line toggles when idle so stale values never look valid
  always @(posedge mclk) begin
    fpFaultDetect <= start;
    fpFaultIp <= start ? ip : ~fpFaultIp;
    fpOpIssue <= cnt == 8'h01;
    fpFaultClear <= fpFaultSignal;
    cnt <= start ? delay : cnt - {7'h00, cnt != 8'h00};
    if (fpFaultSignal)
      resumeIp <= fpSavedIp;
    if (!rst_b)
      cnt <= 8'h00;
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the packed register file
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic fpWrEn = 1'b0;
  logic start = 1'b0;
  logic [1:0] cpuMode = 2'h0;
  logic [2:0] fpWrSlot = 3'h0;
  logic [2:0] fpRdSlot = 3'h0;
  logic [7:0] delay = 8'h00;
  logic [47:0] ip = 48'h0;
  logic [63:0] fpWrData = 64'h0;
  psr_pkg::psr_req_t req = '0;
  psr_pkg::psr_rsp_t rsp;
  logic [63:0] memWrData, fpRdData, pr;
  logic [63:0] mdl [8];
  logic [7:0] memByteEn;
  logic fpFaultDetect, fpFaultClear, fpOpIssue, fpFaultSignal, fpFaultPending, pv;
  logic [47:0] fpFaultIp, fpSavedIp, resumeIp;
  logic [2:0] pd;
  logic [63:0] expQ [$];
  logic [7:0] mskQ [$];
  logic [63:0] expV;
  int seed = 16190;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  psr_pkg::psr_op_t ops [8] = '{psr_pkg::PSR_OP_LOAD64, psr_pkg::PSR_OP_LOAD32,
    psr_pkg::PSR_OP_GPR_IN, psr_pkg::PSR_OP_MOVE_RR, psr_pkg::PSR_OP_ADD_SSAT,
    psr_pkg::PSR_OP_ADD_WRAP, psr_pkg::PSR_OP_XOR, psr_pkg::PSR_OP_AND};
  psr_regfile i_psr_regfile (.mclk, .rst_b, .ce, .req, .rsp, .memWrData, .memByteEn,
    .cpuMode, .fpWrEn, .fpWrSlot, .fpWrData, .fpRdSlot, .fpRdData, .fpFaultDetect,
    .fpFaultIp, .fpFaultClear, .fpOpIssue, .fpFaultSignal, .fpFaultPending, .fpSavedIp);
  psr_core_model i_psr_core_model (.mclk, .rst_b, .start, .delay, .ip, .fpFaultSignal,
    .fpSavedIp, .fpFaultDetect, .fpFaultIp, .fpOpIssue, .fpFaultClear, .resumeIp);
  always #20 mclk = ~mclk;
  // Compare one value and report a mismatch at once
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Reference result of one operation
  function automatic logic [63:0] calc(input psr_pkg::psr_op_t op, input logic [63:0] a, b, m);
    logic [63:0] r;
    int s;
    r = a & b;
    case (op)
      psr_pkg::PSR_OP_LOAD64: r = m;
      psr_pkg::PSR_OP_LOAD32: r = {32'h0, m[31:0]};
      psr_pkg::PSR_OP_GPR_IN: r = {32'h0, m[63:32]};
      psr_pkg::PSR_OP_MOVE_RR: r = a;
      psr_pkg::PSR_OP_XOR: r = a ^ b;
      psr_pkg::PSR_OP_ADD_WRAP: for (int i = 0; i < 8; i++) r[8*i+:8] = a[8*i+:8] + b[8*i+:8];
      psr_pkg::PSR_OP_ADD_SSAT: for (int i = 0; i < 4; i++) begin
        s = $signed(a[16*i+:16]) + $signed(b[16*i+:16]);
        r[16*i+:16] = s > 32767 ? psr_pkg::SAT_WORD_MAX :
          s < -32768 ? psr_pkg::SAT_WORD_MIN : s[15:0];
      end
      default: ;
    endcase
    return r;
  endfunction
  // Drive one request; operands are read before the previous write lands
  task automatic issue(input psr_pkg::psr_op_t op, input logic [2:0] d, a, b, input logic [63:0] m);
    psr_pkg::psr_lane_t ln;
    logic [63:0] nx;
    ln = op == psr_pkg::PSR_OP_ADD_WRAP ? psr_pkg::PSR_LANE_BYTE : (op == psr_pkg::PSR_OP_LOAD32
      || op == psr_pkg::PSR_OP_GPR_IN) ? psr_pkg::PSR_LANE_DWORD : psr_pkg::PSR_LANE_WORD;
    expQ.push_back(mdl[a]);
    mskQ.push_back(ln == psr_pkg::PSR_LANE_DWORD ? 8'h0f : 8'hff);
    nx = calc(op, mdl[a], mdl[b], m);
    if (pv)
      mdl[pd] = pr;
    pr = nx;
    pv = op != psr_pkg::PSR_OP_FP_SYNC;
    pd = d;
    @(posedge mclk);
    req <= '{1'b1, op, ln, d, a, b, m, m[63:32]};
    cpuMode <= m[1:0];
  endtask
  task automatic idle(input int n);
    if (pv)
      mdl[pd] = pr;
    pv = 1'b0;
    repeat (n) @(posedge mclk) req.valid <= 1'b0;
  endtask
  // Scoreboard: each response takes the oldest noted read-out
  always @(negedge mclk) if (rsp.valid === 1'b1) begin
    expV = expQ.size() ? expQ.pop_front() : ~rsp.data64;
    chk(rsp.data64, expV);
    chk({32'h0, rsp.data32}, {32'h0, expV[31:0]});
    chk(memWrData, expV);
    chk({56'h0, memByteEn}, {56'h0, mskQ.size() ? mskQ.pop_front() : ~memByteEn});
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    foreach (mdl[i]) mdl[i] = psr_pkg::REG_RESET;
    pv = 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) issue(psr_pkg::PSR_OP_AND, 3'(i), 3'(i), 3'(i), 64'h0);
    issue(psr_pkg::PSR_OP_LOAD64, 3'h1, 3'h0, 3'h0, 64'h7fff_8000_1234_7ff0);
    issue(psr_pkg::PSR_OP_LOAD64, 3'h2, 3'h1, 3'h0, 64'h0001_ffff_0010_0020);
    idle(1);
    issue(psr_pkg::PSR_OP_ADD_SSAT, 3'h3, 3'h1, 3'h2, 64'h0);
    issue(psr_pkg::PSR_OP_MOVE_RR, 3'h4, 3'h3, 3'h0, 64'h0);
    idle(1);
    issue(psr_pkg::PSR_OP_XOR, 3'h5, 3'h3, 3'h0, 64'h0);
    for (int k = 0; k < 40; k++)
      issue(ops[$unsigned($random(seed)) % 8], 3'($random(seed)), 3'($random(seed)),
        3'($random(seed)), {$random(seed), $random(seed)});
    idle(3);
    ce <= 1'b0; // Frozen cycle: this fp write to slot 5 must not land
    fpWrEn <= 1'b1;
    fpWrSlot <= 3'h5;
    fpWrData <= 64'h5a5a_5a5a_5a5a_5a5a;
    @(posedge mclk) ce <= 1'b1;
    fpWrSlot <= 3'h6;
    fpWrData <= 64'h0123_4567_89ab_cdef;
    mdl[6] = 64'h0123_4567_89ab_cdef;
    @(posedge mclk) fpWrEn <= 1'b0;
    issue(psr_pkg::PSR_OP_MOVE_RR, 3'h7, 3'h6, 3'h0, 64'h0);
    idle(2);
    fpRdSlot <= 3'h7;
    repeat (3) @(posedge mclk);
    @(negedge mclk) chk(fpRdData, mdl[7]);
    @(posedge mclk) fpRdSlot <= 3'h5;
    repeat (2) @(posedge mclk);
    @(negedge mclk) chk(fpRdData, mdl[5]);
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk) start <= 1'b1;
      ip <= 48'({$random(seed), $random(seed)});
      delay <= j ? 8'h00 : 8'h05;
      @(posedge mclk) start <= 1'b0;
      idle(4);
      @(negedge mclk) chk({63'h0, fpFaultPending}, 64'h1);
      chk({16'h0, fpSavedIp}, {16'h0, ip});
      if (j)
        issue(psr_pkg::PSR_OP_FP_SYNC, 3'h0, 3'h0, 3'h0, 64'h0);
      idle(10);
      chk({16'h0, resumeIp}, {16'h0, ip});
      chk({63'h0, fpFaultPending}, 64'h0);
    end
    chk(64'(expQ.size()), 64'h0);
    chk(64'(mskQ.size()), 64'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
